// *** design/tsw_switch_top.sv ***
/*
 Time-slot switch core: captures 32 serial inputs into two banked data
 memories, maps every output channel through two connection memories and
 shifts the result out at a per-stream rate.
 Assumes a register master with one-cycle strobes and read data one
 cycle later; serial pins are asynchronous to core_clk.
*/
module tsw_switch_top #(
	parameter int CYC_PER_BIT = tsw_pkg::CYC_PER_BIT16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Register port
	input wire logic [13:0] reg_addr,
	input wire logic [15:0] reg_wr_data,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rd_data,
	// Frame pulse
	input wire logic master_frame_pulse_in_n,
	// Local port
	input wire logic [15:0] local_serial_in,
	output logic [15:0] local_serial_out,
	output logic [15:0] local_serial_out_oe_n,
	// Backplane port
	input wire logic [15:0] backplane_serial_in,
	output logic [15:0] backplane_serial_out,
	output logic [15:0] backplane_serial_out_oe_n
);
	typedef struct packed {
		logic [1:0][15:0][2:0] in_sync;
		logic [1:0][15:0] in_filt;
		logic [1:0][15:0][7:0] in_shift;
		logic [3:0][15:0][1:0] rate;
		logic [1:0][15:0][7:0] out_shift;
		logic [1:0][15:0][7:0] next_byte;
		logic [1:0][15:0] next_drive;
		logic [1:0][15:0] ser_out;
		logic [1:0][15:0] oe_n;
		logic [1:0][3:0] sched;
		logic [1:0][3:0] stage_stream;
		logic [1:0] stage_valid;
		logic [1:0][15:0] stage_entry;
		logic [1:0][1:0] stage_bank;
		logic [15:0] rd_data;
	} tsw_top_state_t;

	tsw_top_state_t st_q, st_d;
	tsw_timing_if tm();

	// Data memories hold four frames so reads trail writes by three
	logic [7:0] dmem [tsw_pkg::NUM_PORTS][tsw_pkg::NUM_BANKS][tsw_pkg::NUM_STREAMS][tsw_pkg::MAX_CHANNELS];
	logic [15:0] cmem [tsw_pkg::NUM_PORTS][tsw_pkg::NUM_STREAMS][tsw_pkg::MAX_CHANNELS];

	logic [1:0][15:0] dm_we;
	logic [1:0][15:0][7:0] dm_wch;
	logic [1:0][15:0][7:0] dm_wdata;
	logic [1:0][15:0] load_now;

	tsw_frame_timer #(
		.CYC_PER_BIT(CYC_PER_BIT)
	) u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.master_frame_pulse_in_n(master_frame_pulse_in_n),
		.tm(tm)
	);

	function automatic logic [1:0] rate_shift(logic [1:0] r);
		return 2'(2'h3 - r);
	endfunction

	function automatic logic [10:0] fine_mask(logic [1:0] sh);
		return 11'((11'h001 << sh) - 11'h001);
	endfunction

	always_comb begin
		logic [1:0] sh;
		logic [10:0] bn;
		logic [11:0] fut;
		logic [10:0] fbn;
		logic [7:0] nch;
		logic [3:0] k;
		logic [15:0] e;
		logic [7:0] byte_v;
		sh = '0;
		bn = '0;
		fut = '0;
		fbn = '0;
		nch = '0;
		k = '0;
		e = '0;
		byte_v = '0;
		st_d = st_q;
		dm_we = '0;
		dm_wch = '0;
		dm_wdata = '0;
		load_now = '0;
		st_d.rd_data = '0;

		for (int p = 0; p < tsw_pkg::NUM_PORTS; p++) begin
			for (int s = 0; s < tsw_pkg::NUM_STREAMS; s++) begin
				// Input capture, rate from the port's input group
				st_d.in_sync[p][s] = {st_q.in_sync[p][s][1:0], p == 0 ? local_serial_in[s] : backplane_serial_in[s]};
				if (st_q.in_sync[p][s][1] == st_q.in_sync[p][s][2]) begin
					st_d.in_filt[p][s] = st_q.in_sync[p][s][1];
				end
				sh = rate_shift(st_q.rate[2 * p][s]);
				bn = tm.pos >> sh;
				if (tm.synced && tm.bit_mid && (tm.pos & fine_mask(sh)) == fine_mask(sh)) begin
					st_d.in_shift[p][s] = {st_q.in_shift[p][s][6:0], st_q.in_filt[p][s]};
					if (bn[2:0] == 3'h7) begin
						dm_we[p][s] = 1'b1;
						dm_wch[p][s] = bn[10:3];
						dm_wdata[p][s] = st_d.in_shift[p][s];
					end
				end

				// Output shifter, rate from the port's output group
				sh = rate_shift(st_q.rate[2 * p + 1][s]);
				bn = tm.pos >> sh;
				if (tm.synced && tm.bit_start && (tm.pos & fine_mask(sh)) == 11'h000) begin
					if (bn[2:0] == 3'h0) begin
						load_now[p][s] = 1'b1;
						st_d.ser_out[p][s] = st_q.next_byte[p][s][7];
						st_d.out_shift[p][s] = {st_q.next_byte[p][s][6:0], 1'b0};
						st_d.oe_n[p][s] = !st_q.next_drive[p][s];
					end else begin
						st_d.ser_out[p][s] = st_q.out_shift[p][s][7];
						st_d.out_shift[p][s] = {st_q.out_shift[p][s][6:0], 1'b0};
					end
				end
			end

			// Prefetch stage 1: look up the entry of the next byte of one stream
			k = st_q.sched[p];
			sh = rate_shift(st_q.rate[2 * p + 1][k]);
			fut = 12'({1'b0, tm.pos}) + (12'h008 << sh);
			fbn = fut[10:0] >> sh;
			nch = fbn[10:3];
			st_d.stage_entry[p] = cmem[p][k][nch];
			st_d.stage_stream[p] = k;
			st_d.stage_valid[p] = tm.synced;
			// Frame f reads bank f+1, written three frames earlier
			st_d.stage_bank[p] = 2'(tm.frame + 2'h1 + {1'b0, fut[11]});
			st_d.sched[p] = 4'(k + 4'h1);

			// Prefetch stage 2: take the byte from the entry in message mode, else fetch it from either data memory
			if (st_q.stage_valid[p]) begin
				e = st_q.stage_entry[p];
				if (e[tsw_pkg::CE_MSG_BIT]) begin
					byte_v = e[7:0];
				end else begin
					byte_v = dmem[e[tsw_pkg::CE_SRC_BIT]][st_q.stage_bank[p]][e[tsw_pkg::CE_STREAM_LSB +: 4]][e[7:0]];
				end
				st_d.next_byte[p][st_q.stage_stream[p]] = byte_v;
				st_d.next_drive[p][st_q.stage_stream[p]] = e[tsw_pkg::CE_DRIVE_BIT];
			end
		end

		// Register port
		if (reg_wr) begin
			if (!reg_addr[tsw_pkg::CM_SEL_BIT] && reg_addr < tsw_pkg::RATE_SPAN) begin
				st_d.rate[reg_addr[5:4]][reg_addr[3:0]] = reg_wr_data[1:0];
			end
		end
		if (reg_rd) begin
			if (reg_addr[tsw_pkg::CM_SEL_BIT]) begin
				st_d.rd_data = cmem[reg_addr[tsw_pkg::CM_PORT_BIT]][reg_addr[tsw_pkg::CM_STREAM_LSB +: 4]][reg_addr[7:0]];
			end else if (reg_addr < tsw_pkg::RATE_SPAN) begin
				st_d.rd_data = {14'h0000, st_q.rate[reg_addr[5:4]][reg_addr[3:0]]};
			end else if (reg_addr == tsw_pkg::STATUS_ADDR) begin
				st_d.rd_data = {13'h0000, tm.synced, tm.frame};
			end
		end

		if (srst) begin
			st_d = '0;
			st_d.rate = {64{tsw_pkg::RATE_RESET}};
			st_d.oe_n = '1;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	// Memories sit outside the state record; only connection memory is cleared
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int p = 0; p < tsw_pkg::NUM_PORTS; p++) begin
				for (int s = 0; s < tsw_pkg::NUM_STREAMS; s++) begin
					for (int c = 0; c < tsw_pkg::MAX_CHANNELS; c++) begin
						cmem[p][s][c] <= tsw_pkg::CE_RESET;
					end
				end
			end
		end else if (reg_wr && reg_addr[tsw_pkg::CM_SEL_BIT]) begin
			cmem[reg_addr[tsw_pkg::CM_PORT_BIT]][reg_addr[tsw_pkg::CM_STREAM_LSB +: 4]][reg_addr[7:0]] <= reg_wr_data;
		end
	end

	generate
		for (genvar gp = 0; gp < tsw_pkg::NUM_PORTS; gp++) begin : g_port
			for (genvar gs = 0; gs < tsw_pkg::NUM_STREAMS; gs++) begin : g_stream
				always_ff @(posedge core_clk) begin
					if (dm_we[gp][gs]) begin
						dmem[gp][tm.frame][gs][dm_wch[gp][gs]] <= dm_wdata[gp][gs];
					end
				end
			end
		end
	endgenerate

	assign reg_rd_data = st_q.rd_data;
	assign local_serial_out = st_q.ser_out[tsw_pkg::PORT_LOCAL];
	assign local_serial_out_oe_n = st_q.oe_n[tsw_pkg::PORT_LOCAL];
	assign backplane_serial_out = st_q.ser_out[tsw_pkg::PORT_BACKPLANE];
	assign backplane_serial_out_oe_n = st_q.oe_n[tsw_pkg::PORT_BACKPLANE];

	// Assertion helpers: the last bus write
	logic a_wr_q;
	logic [13:0] a_addr_q;
	logic [15:0] a_wd_q;
	always_ff @(posedge core_clk) begin
		a_wr_q <= reg_wr && !srst;
		a_addr_q <= reg_addr;
		a_wd_q <= reg_wr_data;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	property rate_write_p(logic [1:0] grp);
		a_wr_q && a_addr_q < tsw_pkg::RATE_SPAN && a_addr_q[5:4] == grp
			|-> st_q.rate[grp][a_addr_q[3:0]] == a_wd_q[1:0];
	endproperty

	sequence load_seq(int p, int s);
		load_now[p][s] ##1 1'b1;
	endsequence

	a_lin_rate: assert property (rate_write_p(tsw_pkg::GRP_LOCAL_IN))
		else $error("local input rate write lost");
	a_lout_rate: assert property (rate_write_p(tsw_pkg::GRP_LOCAL_OUT))
		else $error("local output rate write lost");
	a_bin_rate: assert property (rate_write_p(tsw_pkg::GRP_BP_IN))
		else $error("backplane input rate write lost");
	a_bout_rate: assert property (rate_write_p(tsw_pkg::GRP_BP_OUT))
		else $error("backplane output rate write lost");
	a_read_one_cycle: assert property (!$past(reg_rd) |-> reg_rd_data == 16'h0000)
		else $error("read data outside its cycle");
	a_msg_data: assert property (st_q.stage_valid[0] && st_q.stage_entry[0][tsw_pkg::CE_MSG_BIT]
		|=> st_q.next_byte[0][$past(st_q.stage_stream[0])] == $past(st_q.stage_entry[0][7:0]))
		else $error("message byte not taken from entry");
	a_bank_delay: assert property (st_q.stage_valid[1]
		|-> 2'(st_q.stage_bank[1] - tm.frame) == 2'h1 || 2'(st_q.stage_bank[1] - tm.frame) == 2'h2)
		else $error("read bank not three frames behind");
	a_load_msb: assert property (load_seq(0, 0) |-> local_serial_out[0] == $past(st_q.next_byte[0][0][7]))
		else $error("byte start did not send msb");
	a_hiz_follow: assert property (load_seq(1, 3)
		|-> backplane_serial_out_oe_n[3] == !$past(st_q.next_drive[1][3]))
		else $error("drive enable not applied at channel start");
	a_sched_walk: assert property (st_q.stage_stream[0] == $past(st_q.sched[0])
		&& st_q.stage_stream[1] == $past(st_q.sched[1]))
		else $error("prefetch scheduler skipped a stream");
endmodule

// *** design/tsw_pkg.sv ***
/*
 Shared constants for the time-slot switch: stream counts, rate codes,
 register map, connection entry layout and frame timing.
 Assumes a 100 MHz core clock and an active-low master frame pulse.
*/
// Function
// - Two ports, sixteen serial inputs and sixteen serial outputs each.
// - Each local input stream runs at 2, 4, 8 or 16 Mb/s.
// - Each local output stream runs at 2, 4, 8 or 16 Mb/s.
// - Each backplane input stream runs at 2, 4, 8 or 16 Mb/s.
// - Each backplane output stream runs at 2, 4, 8 or 16 Mb/s.
// - Local input rate comes from its own writable per-stream register.
// - Local output rate comes from its own writable per-stream register.
// - Backplane input rate comes from its own writable per-stream register.
// - Backplane output rate comes from its own writable per-stream register.
// - Backplane inputs reach local outputs via local connection memory.
// - Local inputs reach backplane outputs via backplane connection memory.
// - Backplane inputs reach backplane outputs via backplane connection memory.
// - Local inputs reach local outputs via local connection memory.
// - All four paths run concurrently and non-blocking.
// - All 32 inputs and outputs combine into one unidirectional switch.
// - Lower stream rates give proportionally fewer channels.
// - Local entry bits pick message mode, drive enable and source memory.
// - Backplane entry bits pick message mode, drive enable and source memory.
// - Uneven blocking splits between sides are possible.
// - 256, 128, 64 or 32 channels per frame by rate.
// - Constant three-frame delay from input to output.
package tsw_pkg;
	localparam int NUM_PORTS = 2;
	localparam int NUM_STREAMS = 16;
	localparam int PORT_LOCAL = 0;
	localparam int PORT_BACKPLANE = 1;
	localparam int MAX_CHANNELS = 256;
	localparam int NUM_BANKS = 4;
	localparam int THROUGH_DELAY_FRAMES = 3;
	localparam logic [10:0] FRAME_LAST_BIT = 11'h7FF;

	localparam logic [1:0] RATE_2M = 2'h0;
	localparam logic [1:0] RATE_4M = 2'h1;
	localparam logic [1:0] RATE_8M = 2'h2;
	localparam logic [1:0] RATE_16M = 2'h3;
	localparam logic [1:0] RATE_RESET = RATE_16M;

	localparam logic [1:0] GRP_LOCAL_IN = 2'h0;
	localparam logic [1:0] GRP_LOCAL_OUT = 2'h1;
	localparam logic [1:0] GRP_BP_IN = 2'h2;
	localparam logic [1:0] GRP_BP_OUT = 2'h3;

	localparam int ADDR_W = 14;
	localparam logic [13:0] RATE_SPAN = 14'h0040;
	localparam logic [13:0] STATUS_ADDR = 14'h0100;
	localparam int CM_SEL_BIT = 13;
	localparam int CM_PORT_BIT = 12;
	localparam int CM_STREAM_LSB = 8;

	localparam int CE_MSG_BIT = 15;
	localparam int CE_DRIVE_BIT = 14;
	localparam int CE_SRC_BIT = 13;
	localparam int CE_STREAM_LSB = 8;
	localparam logic [15:0] CE_RESET = 16'h0000;

	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT16_PERIOD_PS = 61035;
	localparam int CYC_PER_BIT16 = BIT16_PERIOD_PS / (CLK_PERIOD_NS * 1000);
endpackage

// *** design/tsw_timing_if.sv ***
/*
 Frame timing carried from the frame timer to the switch core.
 Assumes both ends sit on core_clk.
*/
interface tsw_timing_if;
	logic [10:0] pos;
	logic bit_start;
	logic bit_mid;
	logic synced;
	logic [1:0] frame;
	modport src(output pos, bit_start, bit_mid, synced, frame);
	modport dst(input pos, bit_start, bit_mid, synced, frame);
endinterface

// *** design/tsw_frame_timer.sv ***
/*
 Frame timer: synchronises the master frame pulse, counts 16 Mb/s bit
 slots from each boundary and numbers the frames.
 Assumes the pulse is active low and longer than three clocks.
*/
module tsw_frame_timer #(
	parameter int CYC_PER_BIT = tsw_pkg::CYC_PER_BIT16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Frame pulse pin
	input wire logic master_frame_pulse_in_n,
	// Timing to the core
	tsw_timing_if.src tm
);
	typedef struct packed {
		logic [2:0] fp_sync;
		logic fp_filt;
		logic [7:0] sub;
		logic [10:0] pos;
		logic [1:0] frame;
		logic bit_start;
		logic bit_mid;
		logic synced;
		logic running;
	} tsw_timer_state_t;

	localparam logic [7:0] SUB_LAST = 8'(CYC_PER_BIT - 1);
	localparam logic [7:0] SUB_MID = 8'(CYC_PER_BIT / 2);

	if (CYC_PER_BIT < 2 || CYC_PER_BIT > 255) begin : g_chk
		$error("CYC_PER_BIT out of range");
	end

	tsw_timer_state_t st_q, st_d;
	logic boundary;

	always_comb begin
		st_d = st_q;
		st_d.bit_start = 1'b0;
		st_d.bit_mid = 1'b0;
		st_d.fp_sync = {st_q.fp_sync[1:0], master_frame_pulse_in_n};
		if (st_q.fp_sync[1] == st_q.fp_sync[2]) begin
			st_d.fp_filt = st_q.fp_sync[1];
		end
		boundary = st_q.fp_filt && !st_d.fp_filt;
		if (boundary) begin
			st_d.pos = '0;
			st_d.sub = '0;
			st_d.frame = 2'(st_q.frame + 2'h1);
			st_d.synced = 1'b1;
			st_d.running = 1'b1;
			st_d.bit_start = 1'b1;
		end else if (st_q.running) begin
			if (st_q.sub == SUB_LAST) begin
				st_d.sub = '0;
				// Hold at frame end so a late pulse never counts twice
				if (st_q.pos == tsw_pkg::FRAME_LAST_BIT) begin
					st_d.running = 1'b0;
				end else begin
					st_d.pos = 11'(st_q.pos + 11'h1);
					st_d.bit_start = 1'b1;
				end
			end else begin
				st_d.sub = 8'(st_q.sub + 8'h1);
				st_d.bit_mid = (st_d.sub == SUB_MID);
			end
		end
		if (srst) begin
			st_d = '0;
			st_d.fp_sync = 3'h7;
			st_d.fp_filt = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		st_q <= st_d;
	end

	assign tm.pos = st_q.pos;
	assign tm.bit_start = st_q.bit_start;
	assign tm.bit_mid = st_q.bit_mid;
	assign tm.synced = st_q.synced;
	assign tm.frame = st_q.frame;

	a_frame_resync: assert property (@(posedge core_clk) disable iff (srst)
		$fell(st_q.fp_filt) |-> (st_q.pos == 11'h000) && st_q.bit_start && st_q.sub == 8'h00)
		else $error("frame boundary did not restart bit count");
endmodule

// *** dv/tsw_dv_pkg.sv ***
/*
 Bench helpers shared by the far-end model and the test: frame length,
 capture frame and the byte pattern sent in every channel.
 Assumes tsw_pkg is compiled first.
*/
package tsw_dv_pkg;
	localparam int FRAME_CLKS = 12500;
	localparam int CAP_FRAME = 4;
	// Frame number in the byte makes a wrong delay visible
	function automatic logic [7:0] pat(input int p, input int s, input int c, input int f);
		return 8'((p * 101) + (s * 17) + (c * 7) + (f * 37));
	endfunction
endpackage

// *** dv/tsw_far_end.sv ***
/*
 Far-end model: framers on both ports plus the frame timing source.
 Sends a known byte in every channel, records one whole output frame.
 Assumes the switch samples and drives relative to the pulse edge.
*/
module tsw_far_end #(
	parameter int CPB = 6,
	parameter int OFS = 8
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic run,
	input wire logic [1:0][15:0][1:0] rin,
	input wire logic [1:0][15:0][1:0] rout,
	// Switch pins
	output logic master_frame_pulse_in_n,
	output logic [1:0][15:0] ser_in,
	input wire logic [1:0][15:0] ser_out,
	input wire logic [1:0][15:0] oe_n,
	// Captured frame
	output int frm,
	output logic [7:0] cap [2][16][256],
	output logic cap_z [2][16][256]
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = tsw_dv_pkg::FRAME_CLKS - 1;
	initial begin
		frm = -1;
		master_frame_pulse_in_n = 1'b1;
		ser_in = '0;
	end
	always @(posedge core_clk) begin
		int t, m, b;
		logic [7:0] d;
		if (run) begin
			t = cnt - OFS;
			if (frm == tsw_dv_pkg::CAP_FRAME && t >= 0 && t % CPB == 0 && t / CPB < 2048) begin
				t = t / CPB;
				for (int p = 0; p < 2; p++)
					for (int s = 0; s < 16; s++) begin
						m = 1 << (3 - rout[p][s]);
						b = t / m;
						// Last fine slot of each bit, well clear of its edges
						if (t % m == m - 1) begin
							cap[p][s][b / 8][7 - b % 8] = ser_out[p][s];
							if (b % 8 == 0)
								cap_z[p][s][b / 8] = oe_n[p][s];
						end
					end
			end
			cnt = cnt == tsw_dv_pkg::FRAME_CLKS - 1 ? 0 : cnt + 1;
			if (cnt == 0)
				frm++;
			master_frame_pulse_in_n <= cnt >= 4;
			for (int p = 0; p < 2; p++)
				for (int s = 0; s < 16; s++) begin
					m = 1 << (3 - rin[p][s]);
					b = cnt / CPB / m;
					d = tsw_dv_pkg::pat(p, s, b / 8, frm);
					// Toggling between frames so no stale bit can pass
					ser_in[p][s] <= cnt < 2048 * CPB ? d[7 - b % 8] : ~ser_in[p][s];
				end
		end
	end
endmodule

// *** dv/tdm_time_slot_switch_paths_test.sv ***
/*
 Self-checking test of the time-slot switch: rate and connection
 registers, then a mixed-rate frame through all four paths.
 Assumes tsw_pkg, tsw_dv_pkg and the far-end model are compiled first.
*/
module tdm_time_slot_switch_paths_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [13:0] reg_addr = '0;
	logic [15:0] reg_wr_data = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rd_data;
	logic run = 1'b0;
	logic pulse_n;
	logic [1:0][15:0] ser_in;
	logic [1:0][15:0] ser_out;
	logic [1:0][15:0] oe_n;
	logic [1:0][15:0][1:0] rin = '0;
	logic [1:0][15:0][1:0] rout = '0;
	logic [7:0] cap [2][16][256];
	logic cap_z [2][16][256];
	int frm;
	logic [15:0] rs = 16'hABA0;
	logic [15:0] ent [int];
	int n_fail = 0;
	int comparisons = 0;

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	tsw_switch_top dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .master_frame_pulse_in_n(pulse_n),
		.local_serial_in(ser_in[0]), .local_serial_out(ser_out[0]), .local_serial_out_oe_n(oe_n[0]),
		.backplane_serial_in(ser_in[1]), .backplane_serial_out(ser_out[1]), .backplane_serial_out_oe_n(oe_n[1]));

	tsw_far_end far (.core_clk(core_clk), .run(run), .rin(rin), .rout(rout), .master_frame_pulse_in_n(pulse_n),
		.ser_in(ser_in), .ser_out(ser_out), .oe_n(oe_n), .frm(frm), .cap(cap), .cap_z(cap_z));

	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [13:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rd_data;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#950000;
		n_fail++;
		complete_run();
	end

	initial begin
		logic [15:0] d, e;
		logic [13:0] a;
		logic [1:0] code;
		int nch, ch, w;
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		rd(tsw_pkg::STATUS_ADDR, d);
		chk(d, 16'h0000);
		chk(oe_n[0], 16'hFFFF);
		chk(oe_n[1], 16'hFFFF);
		for (int i = 0; i < 64; i++) begin
			rd(14'(i), d);
			chk(d, {14'h0000, tsw_pkg::RATE_RESET});
			rs = nxt(rs);
			wr(14'(i), rs);
			rd(14'(i), d);
			chk(d, {14'h0000, rs[1:0]});
		end
		wr(14'h0080, 16'hFFFF);
		rd(14'h0080, d);
		chk(d, 16'h0000);
		// Every group sees all four rates
		for (int i = 0; i < 64; i++) begin
			code = 2'(i % 4 + i / 16);
			wr(14'(i), {14'h0000, code});
			if (i / 16 % 2 == 1)
				rout[i / 32][i % 16] = code;
			else
				rin[i / 32][i % 16] = code;
		end
		// Channel 1 stays unprogrammed; first and last channels always used
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 16; s++)
				for (int k = 0; k < 4; k++) begin
					nch = 32 << rout[p][s];
					rs = nxt(rs);
					ch = k == 0 ? 0 : k == 1 ? nch - 1 : 2 + rs[15:8] % (nch - 2);
					e = {k == 2, !(k == 3 && rs[5]), rs[0], 1'b0, rs[4:1],
						8'(k == 2 ? rs[15:8] : rs[13:6] % (32 << rin[rs[0]][rs[4:1]]))};
					a = 14'h2000 | 14'(p << 12) | 14'(s << 8) | 14'(ch);
					wr(a, e);
					rd(a, d);
					chk(d, e);
					ent[a] = e;
				end
		run <= 1'b1;
		w = 0;
		while (frm <= tsw_dv_pkg::CAP_FRAME && w < 90000) begin
			@(posedge core_clk);
			w++;
		end
		chk(16'(frm > tsw_dv_pkg::CAP_FRAME), 16'h0001);
		rd(tsw_pkg::STATUS_ADDR, d);
		chk(16'(d[2]), 16'h0001);
		foreach (ent[x]) begin
			e = ent[x];
			a = 14'(x);
			chk(16'(cap_z[a[12]][a[11:8]][a[7:0]]), 16'(!e[14]));
			d = e[15] ? 16'(e[7:0]) : 16'(tsw_dv_pkg::pat(e[13], e[11:8], e[7:0],
				tsw_dv_pkg::CAP_FRAME - tsw_pkg::THROUGH_DELAY_FRAMES));
			if (e[14])
				chk(16'(cap[a[12]][a[11:8]][a[7:0]]), d);
		end
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 16; s++)
				chk(16'(cap_z[p][s][1]), 16'h0001);
		complete_run();
	end
endmodule
